// >>> inc/wseq_pkg.sv
package wseq_pkg;
  // one sequencer cycle carries eight output samples per channel
  localparam int SAMPLES_PER_CYCLE = 8;
  localparam int SEQ_SHIFT = $clog2(SAMPLES_PER_CYCLE);
  localparam int SAMPLE_W = 16;
  localparam int LANE_W = SAMPLES_PER_CYCLE * SAMPLE_W;
  localparam int WORD_W = 2 * LANE_W;
  localparam int CACHE_BLOCKS = 256;
  localparam int BLOCK_SA = 1024;
  localparam int BLOCK_WORDS = BLOCK_SA / SAMPLES_PER_CYCLE;
  localparam int BLOCK_SHIFT = $clog2(BLOCK_WORDS);
  localparam int CACHE_WORDS = CACHE_BLOCKS * BLOCK_WORDS;
  localparam int CACHE_AW = $clog2(CACHE_WORDS);
  localparam int HEAD_SA = 2048;
  localparam int ADDR_W = 20;
  localparam int LEN_W = 20;
  localparam int CYC_W = LEN_W - SEQ_SHIFT;
  localparam logic [CYC_W-1:0] HEAD_WORDS = CYC_W'(HEAD_SA / SAMPLES_PER_CYCLE);
  localparam int QDEPTH = 4;
  localparam int NQ = 3;
  localparam int QPLAY = 0;
  localparam int QPREF = 1;
  localparam int QWSET = 2;
  localparam int QNONE = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int FCNT_W = $clog2(FIFO_DEPTH) + 1;
  localparam int TKT_W = 3;
  localparam int RES_W = 16;
  localparam int DIO_W = 16;
  localparam int NUM_UREG = 4;
  localparam int NUM_TRIG = 2;
  localparam int NUM_MARK = 4;

  typedef enum logic [3:0] {
    nop_instr,
    play_waveform_instr,
    play_zeros_instr,
    prefetch_instr,
    wait_cycles_instr,
    wait_trigger_instr,
    set_trigger_out_instr,
    read_digital_io_instr,
    read_trigger_state_instr,
    read_user_register_instr
  } op_t;

  typedef enum logic [1:0] {
    SRC_HOLD,
    SRC_CACHE,
    SRC_FIFO,
    SRC_ZERO
  } src_t;

  typedef struct packed {
    logic [TKT_W-1:0] ticket;
    op_t op;
    logic [7:0] block;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] len;
  } q_entry_t;
endpackage : wseq_pkg

// >>> hw/stream_fifo.sv
module stream_fifo #(
  parameter int W = 256,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_t;

  fifo_t fifo_reg;
  fifo_t fifo_next;
  logic push;
  logic pop;

  always_comb begin
    fifo_next = fifo_reg;
    push = in_valid_i && (fifo_reg.cnt != FULL);
    pop = out_ready_i && (fifo_reg.cnt != '0);
    if (push) begin
      fifo_next.mem[fifo_reg.wr] = in_data_i;
      fifo_next.wr = fifo_reg.wr + 1'b1;
    end
    if (pop) begin
      fifo_next.rd = fifo_reg.rd + 1'b1;
    end
    fifo_next.cnt = fifo_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

  assign in_ready_o = fifo_reg.cnt != FULL;
  assign out_valid_o = fifo_reg.cnt != '0;
  assign out_data_o = fifo_reg.mem[fifo_reg.rd];
  assign count_o = fifo_reg.cnt;
endmodule : stream_fifo

// >>> hw/waveform_sequencer_core.sv
// Summary of operation
// - one sequencer cycle equals eight output samples per channel
// - playback, wait-cycles and set-trigger instructions take a fixed, known number of cycles; wait trigger lasts until the trigger
// - a playback starts only after the previous playback has finished
// - back-to-back playbacks are output with no idle cycle between them
// - other than nop and reads, instructions go to playback, prefetch or wait/set queues
// - prefetch entries copy main memory into cache as early as possible
// - playback and wait/set entries run only when the timing unit releases them
// - value-returning instructions wait for empty queues and block dispatch
// - cache holds 256 blocks of 1024 dual-channel samples
// - playback reads its first 2048 samples from cache
// - samples past the cached head stream through a fifo
// - stream reads run ahead, leaving idle memory time for prefetch
// - zero playback emits zeros without reading memory, queued like playback
// - wait of m cycles lasts as long as zero playback of 8m samples
// - wait takes a runtime duration; output holds last sample when idle
// - four markers, two per channel, route only to this pair's outputs
module waveform_sequencer_core
  import wseq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [3:0] instr_op_i,
  input wire logic [ADDR_W-1:0] instr_addr_i,
  input wire logic [7:0] instr_block_i,
  input wire logic [LEN_W-1:0] instr_len_i,
  output logic instr_ready_o,
  output logic result_valid_o,
  output logic [RES_W-1:0] result_data_o,
  input wire logic [NUM_TRIG-1:0] trig_in_i,
  input wire logic [DIO_W-1:0] dio_i,
  input wire logic [NUM_UREG*RES_W-1:0] user_reg_i,
  output logic [NUM_TRIG-1:0] trig_out_o,
  output logic mem_rd_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_rvalid_i,
  input wire logic [WORD_W-1:0] mem_rdata_i,
  input wire logic [1:0] marker_sel0_i,
  input wire logic [1:0] marker_sel1_i,
  output logic [LANE_W-1:0] ch0_samples_o,
  output logic [LANE_W-1:0] ch1_samples_o,
  output logic [1:0] marker_o,
  output logic playing_o,
  output logic underrun_o
);

  typedef struct packed {
    q_entry_t [NQ-1:0][QDEPTH-1:0] q;
    logic [NQ-1:0][2:0] cnt;
    logic [NQ-1:0][1:0] rd;
    logic [TKT_W-1:0] tkt_in;
    logic [TKT_W-1:0] tkt_out;
    logic ready;
    logic get_pend;
    op_t get_op;
    logic [1:0] get_sel;
    logic res_valid;
    logic [RES_W-1:0] res_data;
    logic tl_busy;
    op_t tl_op;
    logic [CYC_W-1:0] tl_left;
    logic tl_trig;
    logic [CACHE_AW-1:0] pb_base;
    logic [CYC_W-1:0] pb_off;
    src_t src;
    logic stream_on;
    logic [ADDR_W-1:0] stream_addr;
    logic [CYC_W-1:0] stream_left;
    logic pf_on;
    logic [ADDR_W-1:0] pf_addr;
    logic [CYC_W-1:0] pf_left;
    logic [FCNT_W-1:0] pend_cnt;
    logic pend_stream;
    logic [CACHE_AW-1:0] resp_waddr;
    logic mem_rd;
    logic [ADDR_W-1:0] mem_addr;
    logic [LANE_W-1:0] ch0;
    logic [LANE_W-1:0] ch1;
    logic [1:0] marker;
    logic playing;
    logic underrun;
    logic [NUM_TRIG-1:0] trig_out;
    logic [NUM_TRIG-1:0] trig_s1;
    logic [NUM_TRIG-1:0] trig_s2;
    logic [DIO_W-1:0] dio_s1;
    logic [DIO_W-1:0] dio_s2;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // never shorter than one cycle, so the slot counter cannot wrap
  function automatic logic [CYC_W-1:0] min1(input logic [CYC_W-1:0] c);
    min1 = (c == '0) ? CYC_W'(1) : c;
  endfunction : min1

  function automatic logic [1:0] queue_of(input op_t op);
    unique case (op)
      play_waveform_instr, play_zeros_instr: queue_of = 2'(QPLAY);
      prefetch_instr: queue_of = 2'(QPREF);
      wait_cycles_instr, wait_trigger_instr, set_trigger_out_instr: queue_of = 2'(QWSET);
      default: queue_of = 2'(QNONE);
    endcase
  endfunction : queue_of

  function automatic logic is_get(input op_t op);
    is_get = (op == read_digital_io_instr) || (op == read_trigger_state_instr) ||
             (op == read_user_register_instr);
  endfunction : is_get

  function automatic logic [CACHE_AW-1:0] block_base(input logic [7:0] blk);
    block_base = CACHE_AW'({blk, {BLOCK_SHIFT{1'b0}}});
  endfunction : block_base

  logic [WORD_W-1:0] cache_mem [CACHE_WORDS];
  logic [WORD_W-1:0] cache_q;
  logic [CACHE_AW-1:0] cache_rd_addr;
  logic cache_we;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;
  logic [FCNT_W-1:0] fifo_count;

  // streaming buffer between main memory and the sample path
  stream_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_stream_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(mem_rdata_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(fifo_out_ready),
    .count_o(fifo_count)
  );

  always_comb begin
    logic slot_free;
    logic [NQ-1:0] pop;
    logic [1:0] qi;
    logic [1:0] slot;
    logic all_empty;
    logic issue;
    logic credit;
    logic [NUM_MARK-1:0] marks;
    q_entry_t h_play;
    q_entry_t h_ws;
    q_entry_t h_pf;
    q_entry_t ent;
    op_t op_in;
    slot_free = 1'b0;
    pop = '0;
    qi = '0;
    slot = '0;
    all_empty = 1'b0;
    issue = 1'b0;
    credit = 1'b0;
    marks = '0;
    ent = '0;
    op_in = op_t'(instr_op_i);
    h_play = state_reg.q[QPLAY][state_reg.rd[QPLAY]];
    h_ws = state_reg.q[QWSET][state_reg.rd[QWSET]];
    h_pf = state_reg.q[QPREF][state_reg.rd[QPREF]];
    state_next = state_reg;
    state_next.res_valid = 1'b0;
    state_next.mem_rd = 1'b0;
    state_next.trig_s1 = trig_in_i;
    state_next.trig_s2 = state_reg.trig_s1;
    state_next.dio_s1 = dio_i;
    state_next.dio_s2 = state_reg.dio_s1;
    cache_rd_addr = '0;
    cache_we = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_out_ready = 1'b0;

    // first stage: the running timeline item picks this cycle's source
    state_next.src = SRC_HOLD;
    if (state_reg.tl_busy && state_reg.tl_op == play_zeros_instr) begin
      state_next.src = SRC_ZERO;
    end else if (state_reg.tl_busy && state_reg.tl_op == play_waveform_instr) begin
      if (state_reg.pb_off < HEAD_WORDS) begin
        state_next.src = SRC_CACHE;
        cache_rd_addr = state_reg.pb_base + CACHE_AW'(state_reg.pb_off);
      end else begin
        state_next.src = SRC_FIFO;
      end
    end
    state_next.pb_off = state_reg.pb_off + 1'b1;
    if (state_reg.tl_busy && state_reg.tl_op != wait_trigger_instr) begin
      state_next.tl_left = state_reg.tl_left - 1'b1;
    end

    // timing unit: the slot frees in the last cycle of the running item
    if (!state_reg.tl_busy) begin
      slot_free = 1'b1;
    end else if (state_reg.tl_op == wait_trigger_instr) begin
      slot_free = state_reg.trig_s2[state_reg.tl_trig];
    end else begin
      slot_free = state_reg.tl_left == CYC_W'(1);
    end
    if (slot_free) begin
      state_next.tl_busy = 1'b0;
    end
    // tickets keep program order between the two timed queues
    if (slot_free && state_reg.cnt[QPLAY] != '0 && h_play.ticket == state_reg.tkt_out) begin
      pop[QPLAY] = 1'b1;
      state_next.tkt_out = state_reg.tkt_out + 1'b1;
      state_next.tl_busy = 1'b1;
      state_next.tl_op = h_play.op;
      state_next.tl_left = min1(CYC_W'(h_play.len >> SEQ_SHIFT));
      state_next.pb_off = '0;
      state_next.pb_base = block_base(h_play.block);
      if (h_play.op == play_waveform_instr && (h_play.len >> SEQ_SHIFT) > LEN_W'(HEAD_WORDS)) begin
        state_next.stream_on = 1'b1;
        state_next.stream_addr = h_play.addr + ADDR_W'(HEAD_WORDS);
        state_next.stream_left = CYC_W'(h_play.len >> SEQ_SHIFT) - HEAD_WORDS;
      end
    end else if (slot_free && state_reg.cnt[QWSET] != '0 && h_ws.ticket == state_reg.tkt_out) begin
      pop[QWSET] = 1'b1;
      state_next.tkt_out = state_reg.tkt_out + 1'b1;
      state_next.tl_busy = 1'b1;
      state_next.tl_op = h_ws.op;
      state_next.tl_left = CYC_W'(1);
      state_next.tl_trig = h_ws.block[0];
      if (h_ws.op == wait_cycles_instr) begin
        state_next.tl_left = min1(CYC_W'(h_ws.len));
      end
      if (h_ws.op == set_trigger_out_instr) begin
        state_next.trig_out = h_ws.block[NUM_TRIG-1:0];
      end
    end

    // prefetch engine takes entries without waiting for the timing unit
    if (!state_reg.pf_on && state_reg.cnt[QPREF] != '0) begin
      pop[QPREF] = 1'b1;
      state_next.pf_on = 1'b1;
      state_next.pf_addr = h_pf.addr;
      state_next.pf_left = HEAD_WORDS;
      state_next.resp_waddr = block_base(h_pf.block);
    end
    if (state_reg.pf_on && state_reg.pf_left == '0 && state_reg.pend_cnt == '0) begin
      state_next.pf_on = 1'b0;
    end

    // responses return in order; all outstanding reads share one target
    if (mem_rvalid_i && state_reg.pend_cnt != '0) begin
      if (state_reg.pend_stream) begin
        fifo_in_valid = 1'b1;
      end else begin
        cache_we = 1'b1;
        state_next.resp_waddr = state_reg.resp_waddr + 1'b1;
      end
    end
    // outstanding stream reads plus stored words never exceed the fifo depth
    credit = ({1'b0, state_reg.pend_cnt} + {1'b0, fifo_count}) < (FCNT_W+1)'(FIFO_DEPTH);
    if (state_reg.stream_on && state_reg.stream_left != '0 && credit && fifo_in_ready &&
        (state_reg.pend_cnt == '0 || state_reg.pend_stream)) begin
      issue = 1'b1;
      state_next.pend_stream = 1'b1;
      state_next.mem_addr = state_reg.stream_addr;
      state_next.stream_addr = state_reg.stream_addr + 1'b1;
      state_next.stream_left = state_reg.stream_left - 1'b1;
    end else if (state_reg.pf_on && state_reg.pf_left != '0 &&
                 state_reg.pend_cnt < FCNT_W'(FIFO_DEPTH) &&
                 (state_reg.pend_cnt == '0 || !state_reg.pend_stream)) begin
      issue = 1'b1;
      state_next.pend_stream = 1'b0;
      state_next.mem_addr = state_reg.pf_addr;
      state_next.pf_addr = state_reg.pf_addr + 1'b1;
      state_next.pf_left = state_reg.pf_left - 1'b1;
    end
    if (state_reg.stream_on && state_reg.stream_left == '0) begin
      state_next.stream_on = 1'b0;
    end
    state_next.mem_rd = issue;
    state_next.pend_cnt = state_reg.pend_cnt + FCNT_W'(issue) -
                          FCNT_W'(mem_rvalid_i && state_reg.pend_cnt != '0);

    // second stage: load the output registers from the chosen source
    state_next.underrun = 1'b0;
    unique case (state_reg.src)
      SRC_CACHE: begin
        state_next.ch0 = cache_q[LANE_W-1:0];
        state_next.ch1 = cache_q[WORD_W-1:LANE_W];
      end
      SRC_FIFO: begin
        if (fifo_out_valid) begin
          fifo_out_ready = 1'b1;
          state_next.ch0 = fifo_out_data[LANE_W-1:0];
          state_next.ch1 = fifo_out_data[WORD_W-1:LANE_W];
        end else begin
          state_next.underrun = 1'b1;
        end
      end
      SRC_ZERO: begin
        state_next.ch0 = '0;
        state_next.ch1 = '0;
      end
      SRC_HOLD: begin
      end
    endcase
    state_next.playing = (state_reg.src != SRC_HOLD) && !state_next.underrun;
    // marker bits ride in the two low bits of lane 0 of each channel
    marks = {state_next.ch1[1:0], state_next.ch0[1:0]};
    state_next.marker = {marks[marker_sel1_i], marks[marker_sel0_i]};

    // value-returning instructions run only with every queue drained
    all_empty = (state_reg.cnt == '0) && !state_reg.tl_busy && (state_reg.src == SRC_HOLD);
    if (state_reg.get_pend && all_empty) begin
      state_next.get_pend = 1'b0;
      state_next.res_valid = 1'b1;
      state_next.res_data = '0;
      unique case (state_reg.get_op)
        read_digital_io_instr: state_next.res_data = state_reg.dio_s2;
        read_trigger_state_instr: state_next.res_data = RES_W'(state_reg.trig_s2);
        default: state_next.res_data = user_reg_i[state_reg.get_sel*RES_W +: RES_W];
      endcase
    end

    for (int i = 0; i < NQ; i++) begin
      if (pop[i]) begin
        state_next.rd[i] = state_reg.rd[i] + 1'b1;
        state_next.cnt[i] = state_reg.cnt[i] - 1'b1;
      end
    end

    // dispatch: one instruction per cycle while ready is high
    if (state_reg.ready && instr_valid_i) begin
      qi = queue_of(op_in);
      if (is_get(op_in)) begin
        state_next.get_pend = 1'b1;
        state_next.get_op = op_in;
        state_next.get_sel = instr_block_i[1:0];
      end else if (qi != 2'(QNONE)) begin
        ent.op = op_in;
        ent.block = instr_block_i;
        ent.addr = instr_addr_i;
        ent.len = instr_len_i;
        ent.ticket = state_reg.tkt_in;
        if (qi != 2'(QPREF)) begin
          state_next.tkt_in = state_reg.tkt_in + 1'b1;
        end
        slot = 2'(state_next.rd[qi] + state_next.cnt[qi][1:0]);
        state_next.q[qi][slot] = ent;
        state_next.cnt[qi] = state_next.cnt[qi] + 1'b1;
      end
    end
    // ready is registered, so it already accounts for this cycle's push
    state_next.ready = !state_next.get_pend;
    for (int i = 0; i < NQ; i++) begin
      if (state_next.cnt[i] >= 3'(QDEPTH)) begin
        state_next.ready = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // cache has no reset; contents are defined by prefetch before use
  always_ff @(posedge sys_clk_i) begin
    if (cache_we) begin
      cache_mem[state_reg.resp_waddr] <= mem_rdata_i;
    end
    cache_q <= cache_mem[cache_rd_addr];
  end

  assign instr_ready_o = state_reg.ready;
  assign result_valid_o = state_reg.res_valid;
  assign result_data_o = state_reg.res_data;
  assign trig_out_o = state_reg.trig_out;
  assign mem_rd_o = state_reg.mem_rd;
  assign mem_addr_o = state_reg.mem_addr;
  assign ch0_samples_o = state_reg.ch0;
  assign ch1_samples_o = state_reg.ch1;
  assign marker_o = state_reg.marker;
  assign playing_o = state_reg.playing;
  assign underrun_o = state_reg.underrun;
endmodule : waveform_sequencer_core

// >>> verification/waveform_sequencer_core_monitor.sv
module waveform_sequencer_core_monitor
  import wseq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [3:0] instr_op_i,
  input wire logic instr_ready_o,
  input wire logic result_valid_o,
  input wire logic mem_rd_o,
  input wire logic mem_rvalid_i,
  input wire logic [1:0] marker_sel0_i,
  input wire logic [1:0] marker_sel1_i,
  input wire logic [LANE_W-1:0] ch0_samples_o,
  input wire logic [LANE_W-1:0] ch1_samples_o,
  input wire logic [1:0] marker_o,
  input wire logic playing_o,
  input wire logic underrun_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] out_cnt_reg;
  wire logic [3:0] mark_src = {ch1_samples_o[1:0], ch0_samples_o[1:0]};
  wire logic is_read = instr_op_i inside {read_digital_io_instr, read_trigger_state_instr,
                                          read_user_register_instr};

  // reads in flight, so the stream never outruns the fifo space
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_cnt_reg <= 5'h0;
    end else begin
      out_cnt_reg <= out_cnt_reg + 5'(mem_rd_o) - 5'(mem_rvalid_i);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_read_taken;
    instr_valid_i && instr_ready_o && is_read;
  endsequence
  sequence s_pending;
    !instr_ready_o && !result_valid_o;
  endsequence

  a_result_pulse: assert property (result_valid_o |=> !result_valid_o)
    else $error("result pulse longer than one cycle");
  a_read_stall: assert property (s_read_taken |=> s_pending ##[1:1000] result_valid_o)
    else $error("read did not block dispatch or never answered");
  a_get_idle: assert property (result_valid_o |-> !playing_o)
    else $error("read answered while a playback ran");
  a_idle_hold: assert property (!playing_o |-> $stable(ch0_samples_o) && $stable(ch1_samples_o))
    else $error("output moved without a playback");
  a_marker_first: assert property ($stable(marker_sel0_i) |-> marker_o[0] == mark_src[marker_sel0_i])
    else $error("marker 0 not from selected source");
  a_marker_second: assert property ($stable(marker_sel1_i) |-> marker_o[1] == mark_src[marker_sel1_i])
    else $error("marker 1 not from selected source");
  a_reads_bounded: assert property (out_cnt_reg <= 5'h8)
    else $error("more than eight reads outstanding");
  a_underrun_hold: assert property (underrun_o |-> !playing_o)
    else $error("underrun while output loaded");
endmodule : waveform_sequencer_core_monitor

bind waveform_sequencer_core waveform_sequencer_core_monitor mon_u (.*);

// >>> verification/main_mem_model.sv
module main_mem_model
  import wseq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic mem_rd_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  output logic mem_rvalid_o,
  output logic [WORD_W-1:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] addr_q[$];
  int due_q[$];
  int cyc;

  function automatic logic [WORD_W-1:0] word_of(input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] w;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < SAMPLES_PER_CYCLE; k++) begin
        w[c*LANE_W + k*SAMPLE_W +: SAMPLE_W] = {3'(k), 1'(c), a[11:0]};
      end
    end
    return w;
  endfunction : word_of

  // in order, one word per read, latency 1 or 5 cycles
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q.delete();
      due_q.delete();
      cyc = 0;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= '0;
    end else begin
      cyc = cyc + 1;
      if (mem_rd_i === 1'b1) begin
        addr_q.push_back(mem_addr_i);
        due_q.push_back(cyc + (slow_i ? 4 : 0));
      end
      if (due_q.size() > 0 && due_q[0] <= cyc) begin
        void'(due_q.pop_front());
        mem_rvalid_o <= 1'b1;
        mem_rdata_o <= word_of(addr_q.pop_front());
      end else begin
        mem_rvalid_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o; // no stale word left on the bus
      end
    end
  end
endmodule : main_mem_model

// >>> verification/tb_waveform_sequencer_core.sv
module tb_waveform_sequencer_core
  import wseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i, instr_ready_o, result_valid_o, mem_rd_o, mem_rvalid_i;
  logic playing_o, underrun_o, slow;
  logic [3:0] instr_op_i;
  logic [ADDR_W-1:0] instr_addr_i, mem_addr_o;
  logic [7:0] instr_block_i;
  logic [LEN_W-1:0] instr_len_i;
  logic [RES_W-1:0] result_data_o;
  logic [NUM_TRIG-1:0] trig_in_i, trig_out_o;
  logic [DIO_W-1:0] dio_i;
  logic [NUM_UREG*RES_W-1:0] user_reg_i;
  logic [WORD_W-1:0] mem_rdata_i;
  logic [1:0] marker_sel0_i, marker_sel1_i, marker_o;
  logic [LANE_W-1:0] ch0_samples_o, ch1_samples_o;
  logic [WORD_W-1:0] exp_q[$];
  logic [ADDR_W-1:0] rd_q[$];
  int failures = 0, checked = 0, cyc = 0, take_cyc = 0, rises = 0, stalls = 0;
  logic play_prev = 1'b0;

  waveform_sequencer_core dut_u (.*);
  main_mem_model mem_u (.sys_clk_i, .rst_n_i, .slow_i(slow), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));

  always #50 sys_clk_i = ~sys_clk_i;

  task automatic check(input string name, input logic [WORD_W-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // the watchdog counts on the falling edge, clear of the sampling edge
  always @(negedge sys_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      $display("MISMATCH timeout expected done seen hang");
      test_done();
    end
  end

  always @(posedge sys_clk_i) begin
    if (mem_rd_o === 1'b1) rd_q.push_back(mem_addr_o);
    stalls += int'(instr_valid_i && instr_ready_o === 1'b0);
    if (rst_n_i && underrun_o !== 1'b0) check("underrun", underrun_o, 1'b0);
    if (rst_n_i && playing_o === 1'b1) begin
      rises += int'(!play_prev);
      if (exp_q.size() == 0) check("extra playback", 1'b1, 1'b0);
      else check("samples", {ch1_samples_o, ch0_samples_o}, exp_q.pop_front());
    end
    play_prev = (playing_o === 1'b1);
  end

  task automatic issue(input op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] b,
                       input logic [LEN_W-1:0] n);
    @(posedge sys_clk_i);
    #1;
    instr_valid_i = 1'b1;
    instr_op_i = op;
    instr_addr_i = a;
    instr_block_i = b;
    instr_len_i = n;
    do @(posedge sys_clk_i); while (instr_ready_o !== 1'b1);
    take_cyc = cyc;
    #1;
    instr_valid_i = 1'b0;
  endtask : issue

  // expected words are queued before the take so the checker never runs dry
  task automatic play(input logic [ADDR_W-1:0] a, input logic [7:0] b, input int words,
                      input bit zero);
    for (int i = 0; i < words; i++) exp_q.push_back(zero ? '0 : mem_u.word_of(a + ADDR_W'(i)));
    issue(zero ? play_zeros_instr : play_waveform_instr, a, b, LEN_W'(words * 8));
  endtask : play

  task automatic read_back(input op_t op, input logic [7:0] b, input logic [RES_W-1:0] exp);
    issue(op, '0, b, '0);
    do @(posedge sys_clk_i); while (result_valid_o !== 1'b1);
    check("result", result_data_o, exp);
  endtask : read_back

  task automatic await_trig(input logic [1:0] v);
    do @(posedge sys_clk_i); while (trig_out_o !== v);
  endtask : await_trig

  task automatic prefetch(input logic [ADDR_W-1:0] a, input logic [7:0] b);
    rd_q.delete();
    issue(prefetch_instr, a, b, '0);
    while (rd_q.size() < 256 || mem_u.addr_q.size() > 0) @(posedge sys_clk_i);
    check("prefetch reads", rd_q.size(), 256);
    for (int i = 0; i < 256; i++) check("prefetch addr", rd_q[i], a + ADDR_W'(i));
  endtask : prefetch

  initial begin
    int m, t0, t1, t2;
    logic [ADDR_W-1:0] a1, a2;
    void'($urandom(96));
    a1 = ADDR_W'($urandom) & 20'hfff00;
    a2 = a1 ^ 20'h80000;
    instr_valid_i = 1'b0;
    instr_op_i = 4'h0;
    instr_addr_i = '0;
    instr_block_i = '0;
    instr_len_i = '0;
    trig_in_i = '0;
    dio_i = DIO_W'($urandom);
    user_reg_i = {$urandom, $urandom};
    marker_sel0_i = 2'($urandom);
    marker_sel1_i = 2'($urandom);
    slow = 1'b1;
    repeat (16) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    check("ready after reset", instr_ready_o, 1'b1);
    prefetch(a1, 8'h00);
    #1 slow = 1'b0;
    prefetch(a2, 8'h04);
    #1 marker_sel0_i = 2'($urandom);
    marker_sel1_i = 2'($urandom);
    play(a1, 8'h00, 8, 1'b0);
    play(a1, 8'h00, 4, 1'b1);
    play(a1, 8'h00, 16, 1'b0);
    play(a2, 8'h04, 264, 1'b0);
    while (exp_q.size() > 0) @(posedge sys_clk_i);
    check("playback runs", rises, 1);
    m = 3 + $urandom_range(0, 20);
    issue(wait_cycles_instr, '0, '0, LEN_W'(m));
    t0 = take_cyc;
    issue(set_trigger_out_instr, '0, 8'h01, '0);
    await_trig(2'h1);
    t1 = cyc - t0;
    check("hold level", {ch1_samples_o, ch0_samples_o}, mem_u.word_of(a2 + 20'h107));
    play(a1, 8'h00, m, 1'b1);
    t0 = take_cyc;
    issue(set_trigger_out_instr, '0, 8'h02, '0);
    await_trig(2'h2);
    t2 = cyc - t0;
    check("wait against zero play", t2, t1);
    stalls = 0;
    for (int i = 0; i < 6; i++) begin
      issue(wait_cycles_instr, '0, '0, 20'h00028);
      if (i == 0) t0 = take_cyc;
    end
    issue(set_trigger_out_instr, '0, 8'h03, '0);
    await_trig(2'h3);
    check("queued waits", cyc - t0, 240 + t1 - m);
    check("dispatch stall", stalls > 0, 1'b1);
    issue(wait_trigger_instr, '0, 8'h01, '0);
    issue(set_trigger_out_instr, '0, 8'h00, '0);
    repeat (20) @(posedge sys_clk_i);
    check("trigger gate", trig_out_o, 2'h3);
    #1 trig_in_i = 2'h2;
    await_trig(2'h0);
    #1 trig_in_i = 2'($urandom);
    play(a1, 8'h00, 10, 1'b1);
    for (int i = 0; i < 4; i++) read_back(read_user_register_instr, 8'(i), user_reg_i[16*i +: 16]);
    read_back(read_digital_io_instr, '0, dio_i);
    read_back(read_trigger_state_instr, '0, RES_W'(trig_in_i));
    test_done();
  end
endmodule : tb_waveform_sequencer_core
